// ### pkg/gauge_i2c_pkg.sv
// Constants for the battery monitor bus target port.
// Assumes a single 200 MHz clock and an open-drain two-wire bus outside.
// Function
// - Answer only target address 1010101; the address is fixed.
// - Support single, incremental and quick reads, single and incremental writes.
// - Quick read returns the byte at the current pointer, no command byte.
// - Pointer steps on every acknowledged data byte, either side acking.
// - Successive written bytes land at consecutive locations through the pointer.
// - Data written to a read-only location is answered with NACK.
// - A command byte naming a location above 0x6B is answered with NACK.
// - Bus low for limit times 0.5 s releases both SDA and SCL.
// - If a line stays low after that release, the engine goes to sleep.
// - Stretch up to 80 ms on store updates, 270 ms after measure.
// - In deep sleep and lowest power, stretch on every transaction while waking.
// - Wake setting 0x09 gives about 32 us stretch, 0x00 about 4 ms.
// - In normal and light sleep, stretch only for own transactions.
// - Stretch may follow a start, an acknowledge, or first read data bit.
// - Resistance table update stretches at most 24 ms.
// - Stretch bounds 72 ms block write, 116 ms with restore, 144 ms discharge.
package gauge_i2c_pkg;
    // ==========================================
    // Addressing
    localparam logic [6:0] DEV_ADDR = 7'h55;
    localparam logic [7:0] LAST_READ_LOC = 8'h6b;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ==========================================
    // Power states
    localparam logic [1:0] PWR_NORMAL = 2'h0;
    localparam logic [1:0] PWR_LIGHT = 2'h1;
    localparam logic [1:0] PWR_DEEP = 2'h2;
    localparam logic [1:0] PWR_LOWEST = 2'h3;

    // ==========================================
    // Wake stretch setting and store-busy kinds
    localparam logic [7:0] WAKE_CFG_FAST = 8'h09;
    localparam logic [7:0] WAKE_CFG_SLOW = 8'h00;
    localparam logic [2:0] STR_RES_TABLE = 3'h0;
    localparam logic [2:0] STR_BLOCK = 3'h1;
    localparam logic [2:0] STR_RESTORE = 3'h2;
    localparam logic [2:0] STR_DISCHARGE = 3'h3;
    localparam logic [2:0] STR_FLASH = 3'h4;
    localparam logic [2:0] STR_MEASURE = 3'h5;

    // ==========================================
    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_WAKE_FAST_NS = 32000;
    localparam int T_WAKE_SLOW_MS = 4;
    localparam int T_HALF_SEC_MS = 500;
    localparam int T_RES_TABLE_MS = 24;
    localparam int T_BLOCK_MS = 72;
    localparam int T_RESTORE_MS = 116;
    localparam int T_DISCHARGE_MS = 144;
    localparam int T_FLASH_MS = 80;
    localparam int T_MEASURE_MS = 270;
    localparam int MS_CYC = 1000000 / CLK_PERIOD_NS;
    localparam int WAKE_FAST_CYC = T_WAKE_FAST_NS / CLK_PERIOD_NS;
    localparam int WAKE_SLOW_CYC = T_WAKE_SLOW_MS * MS_CYC;
    localparam int HALF_SEC_CYC = T_HALF_SEC_MS * MS_CYC;
    localparam logic [31:0] SETTLE_CYC = 32'h0000_0008;
endpackage

// ### rtl/line_filter.sv
// Three-stage synchroniser and agreement filter for one bus line.
// Assumes the raw line is asynchronous to clk and idles high.
`timescale 1ns/1ps

module line_filter (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Line
    input wire logic raw,
    output logic level
);
    logic ff1, ff2, ff3;
    logic next_level;

    // Only the second and third stages are compared; the first only feeds the second
    always_comb begin
        next_level = level;
        if (ff2 == ff3) begin
            next_level = ff3;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ff1 <= 1'b1;
            ff2 <= 1'b1;
            ff3 <= 1'b1;
            level <= 1'b1;
        end else begin
            ff1 <= raw;
            ff2 <= ff1;
            ff3 <= ff2;
            level <= next_level;
        end
    end
endmodule

// ### rtl/gauge_i2c_slave_port.sv
// Two-wire bus target port: addressing, pointer, acks, stretching, stuck release.
// Assumes a command space outside that answers rd_data for ptr combinationally.
`timescale 1ns/1ps

module gauge_i2c_slave_port #(
    parameter int WAKE_FAST_CYC = gauge_i2c_pkg::WAKE_FAST_CYC,
    parameter int WAKE_SLOW_CYC = gauge_i2c_pkg::WAKE_SLOW_CYC,
    parameter int MS_CYC = gauge_i2c_pkg::MS_CYC,
    parameter int HALF_SEC_CYC = gauge_i2c_pkg::HALF_SEC_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Bus pins
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Command space
    output logic [7:0] ptr,
    input wire logic [7:0] rd_data,
    input wire logic loc_read_only,
    output logic wr_en,
    output logic [7:0] wr_data,
    // Power and store status
    input wire logic [1:0] power_state,
    input wire logic [7:0] wake_cfg,
    input wire logic store_busy,
    input wire logic [2:0] stretch_kind,
    input wire logic [7:0] bus_stuck_limit,
    output logic engine_sleep
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK, ST_SKIP
    } state_e;

    // ==========================================
    // Line sampling
    logic scl_s, sda_s, scl_d, sda_d;
    logic rise, fall, start, stop;

    line_filter u_scl_filter (.clk(clk), .nrst(nrst), .raw(scl_in), .level(scl_s));
    line_filter u_sda_filter (.clk(clk), .nrst(nrst), .raw(sda_in), .level(sda_s));

    assign rise = scl_s & ~scl_d;
    assign fall = ~scl_s & scl_d;
    assign start = scl_s & scl_d & sda_d & ~sda_s;
    assign stop = scl_s & scl_d & ~sda_d & sda_s;
    // Open drain: only ever pull low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;

    // ==========================================
    // Protocol engine
    state_e state, next_state;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shreg, next_shreg;
    logic [7:0] next_ptr, next_wr_data;
    logic next_sda_oe, next_wr_en;
    logic rd_mode, next_rd_mode, acked, next_acked;
    logic addressed, next_addressed, master_ack, next_master_ack;
    logic bus_release;

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_ptr = ptr;
        next_wr_data = wr_data;
        next_sda_oe = sda_oe;
        next_wr_en = 1'b0;
        next_rd_mode = rd_mode;
        next_acked = acked;
        next_addressed = addressed;
        next_master_ack = master_ack;
        if (bus_release) begin
            next_state = ST_IDLE;
            next_sda_oe = 1'b0;
            next_addressed = 1'b0;
        end else if (start) begin
            next_state = ST_ADDR;
            next_bit_cnt = 4'h0;
            next_sda_oe = 1'b0;
            next_addressed = 1'b0;
        end else if (stop) begin
            next_state = ST_IDLE;
            next_sda_oe = 1'b0;
            next_addressed = 1'b0;
        end else if (rise) begin
            case (state)
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    next_shreg = {shreg[6:0], sda_s};
                    next_bit_cnt = bit_cnt + 4'h1;
                end
                ST_RDATA: next_bit_cnt = bit_cnt + 4'h1;
                ST_RDATA_ACK: begin
                    next_master_ack = ~sda_s;
                    if (!sda_s) begin
                        next_ptr = ptr + 8'h01;
                    end
                end
                default: ;
            endcase
        end else if (fall) begin
            case (state)
                ST_ADDR: begin
                    if (bit_cnt == gauge_i2c_pkg::BITS_PER_BYTE) begin
                        if (shreg[7:1] == gauge_i2c_pkg::DEV_ADDR) begin
                            next_state = ST_ADDR_ACK;
                            next_sda_oe = 1'b1;
                            next_addressed = 1'b1;
                            next_rd_mode = shreg[0];
                        end else begin
                            next_state = ST_SKIP;
                        end
                    end
                end
                ST_CMD: begin
                    if (bit_cnt == gauge_i2c_pkg::BITS_PER_BYTE) begin
                        next_state = ST_CMD_ACK;
                        next_acked = (shreg <= gauge_i2c_pkg::LAST_READ_LOC);
                        next_sda_oe = next_acked;
                        if (next_acked) begin
                            next_ptr = shreg;
                        end
                    end
                end
                ST_WDATA: begin
                    if (bit_cnt == gauge_i2c_pkg::BITS_PER_BYTE) begin
                        next_state = ST_WDATA_ACK;
                        next_acked = ~loc_read_only;
                        next_sda_oe = next_acked;
                        next_wr_en = next_acked;
                        next_wr_data = shreg;
                    end
                end
                ST_RDATA: begin
                    if (bit_cnt == gauge_i2c_pkg::BITS_PER_BYTE) begin
                        next_state = ST_RDATA_ACK;
                        next_sda_oe = 1'b0;
                    end else begin
                        next_sda_oe = ~shreg[7];
                        next_shreg = {shreg[6:0], 1'b0};
                    end
                end
                ST_ADDR_ACK: begin
                    next_bit_cnt = 4'h0;
                    if (rd_mode) begin
                        // Quick or repeated-start read from the pointer as it stands
                        next_state = ST_RDATA;
                        next_sda_oe = ~rd_data[7];
                        next_shreg = {rd_data[6:0], 1'b0};
                    end else begin
                        next_state = ST_CMD;
                        next_sda_oe = 1'b0;
                    end
                end
                ST_CMD_ACK: begin
                    next_bit_cnt = 4'h0;
                    next_sda_oe = 1'b0;
                    next_state = acked ? ST_WDATA : ST_SKIP;
                end
                ST_WDATA_ACK: begin
                    next_bit_cnt = 4'h0;
                    next_sda_oe = 1'b0;
                    next_state = ST_WDATA;
                    if (acked) begin
                        next_ptr = ptr + 8'h01;
                    end
                end
                ST_RDATA_ACK: begin
                    next_bit_cnt = 4'h0;
                    if (master_ack) begin
                        next_state = ST_RDATA;
                        next_sda_oe = ~rd_data[7];
                        next_shreg = {rd_data[6:0], 1'b0};
                    end else begin
                        next_state = ST_SKIP;
                        next_sda_oe = 1'b0;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            ptr <= gauge_i2c_pkg::PTR_RESET;
            wr_data <= 8'h00;
            sda_oe <= 1'b0;
            wr_en <= 1'b0;
            rd_mode <= 1'b0;
            acked <= 1'b0;
            addressed <= 1'b0;
            master_ack <= 1'b0;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            ptr <= next_ptr;
            wr_data <= next_wr_data;
            sda_oe <= next_sda_oe;
            wr_en <= next_wr_en;
            rd_mode <= next_rd_mode;
            acked <= next_acked;
            addressed <= next_addressed;
            master_ack <= next_master_ack;
        end
    end

    // ==========================================
    // Clock stretching
    logic stretch_wake, next_stretch_wake, wake_pend, next_wake_pend;
    logic next_scl_oe, ack_point;
    logic [31:0] stretch_cnt, next_stretch_cnt, stretch_cap, next_stretch_cap;
    logic [31:0] busy_cap;
    int busy_ms;

    // Stretch points: leaving an ack, or after the first bit of read data
    assign ack_point = fall & addressed &
        (state == ST_ADDR_ACK || state == ST_CMD_ACK || state == ST_WDATA_ACK ||
         state == ST_RDATA_ACK || (state == ST_RDATA && bit_cnt == 4'h1));

    always_comb begin
        case (stretch_kind)
            gauge_i2c_pkg::STR_RES_TABLE: busy_ms = gauge_i2c_pkg::T_RES_TABLE_MS;
            gauge_i2c_pkg::STR_BLOCK: busy_ms = gauge_i2c_pkg::T_BLOCK_MS;
            gauge_i2c_pkg::STR_RESTORE: busy_ms = gauge_i2c_pkg::T_RESTORE_MS;
            gauge_i2c_pkg::STR_DISCHARGE: busy_ms = gauge_i2c_pkg::T_DISCHARGE_MS;
            gauge_i2c_pkg::STR_FLASH: busy_ms = gauge_i2c_pkg::T_FLASH_MS;
            default: busy_ms = gauge_i2c_pkg::T_MEASURE_MS;
        endcase
        busy_cap = 32'(busy_ms * MS_CYC);
    end

    always_comb begin
        next_scl_oe = scl_oe;
        next_stretch_wake = stretch_wake;
        next_wake_pend = wake_pend;
        next_stretch_cnt = stretch_cnt;
        next_stretch_cap = stretch_cap;
        if (bus_release) begin
            next_scl_oe = 1'b0;
            next_wake_pend = 1'b0;
        end else if (scl_oe) begin
            next_stretch_cnt = stretch_cnt + 32'h1;
            // Hard bound even if the store never reports idle
            if (next_stretch_cnt >= stretch_cap || (!stretch_wake && !store_busy)) begin
                next_scl_oe = 1'b0;
            end
        end else if (start && power_state[1]) begin
            next_wake_pend = 1'b1;
        end else if (fall && wake_pend) begin
            // Any traffic, any address, while waking
            next_wake_pend = 1'b0;
            next_scl_oe = 1'b1;
            next_stretch_wake = 1'b1;
            next_stretch_cnt = 32'h0;
            next_stretch_cap = (wake_cfg == gauge_i2c_pkg::WAKE_CFG_FAST) ?
                32'(WAKE_FAST_CYC) : 32'(WAKE_SLOW_CYC);
        end else if (ack_point && store_busy) begin
            next_scl_oe = 1'b1;
            next_stretch_wake = 1'b0;
            next_stretch_cnt = 32'h0;
            next_stretch_cap = busy_cap;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            scl_oe <= 1'b0;
            stretch_wake <= 1'b0;
            wake_pend <= 1'b0;
            stretch_cnt <= 32'h0;
            stretch_cap <= 32'h0;
        end else begin
            scl_oe <= next_scl_oe;
            stretch_wake <= next_stretch_wake;
            wake_pend <= next_wake_pend;
            stretch_cnt <= next_stretch_cnt;
            stretch_cap <= next_stretch_cap;
        end
    end

    // ==========================================
    // Stuck bus watchdog; limit of zero disables it
    logic [31:0] stuck_sub, next_stuck_sub;
    logic [7:0] stuck_units, next_stuck_units;
    logic released, next_released, next_engine_sleep, next_bus_release;

    always_comb begin
        next_stuck_sub = stuck_sub;
        next_stuck_units = stuck_units;
        next_released = released;
        next_engine_sleep = engine_sleep;
        next_bus_release = 1'b0;
        if (scl_s && sda_s) begin
            next_stuck_sub = 32'h0;
            next_stuck_units = 8'h00;
            next_released = 1'b0;
            next_engine_sleep = 1'b0;
        end else if (released) begin
            // Our drivers are off; a line still low is someone else's
            if (stuck_sub >= gauge_i2c_pkg::SETTLE_CYC) begin
                next_engine_sleep = 1'b1;
            end else begin
                next_stuck_sub = stuck_sub + 32'h1;
            end
        end else if (bus_stuck_limit != 8'h00) begin
            next_stuck_sub = stuck_sub + 32'h1;
            if (stuck_sub == 32'(HALF_SEC_CYC - 1)) begin
                next_stuck_sub = 32'h0;
                next_stuck_units = stuck_units + 8'h01;
                if (next_stuck_units == bus_stuck_limit) begin
                    next_bus_release = 1'b1;
                    next_released = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            stuck_sub <= 32'h0;
            stuck_units <= 8'h00;
            released <= 1'b0;
            engine_sleep <= 1'b0;
            bus_release <= 1'b0;
        end else begin
            stuck_sub <= next_stuck_sub;
            stuck_units <= next_stuck_units;
            released <= next_released;
            engine_sleep <= next_engine_sleep;
            bus_release <= next_bus_release;
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_addr_match: assert property (
        (state == ST_ADDR_ACK && $past(state) == ST_ADDR) |->
            shreg[7:1] == gauge_i2c_pkg::DEV_ADDR && sda_oe)
        else $error("acked a foreign address");
    chk_cmd_range: assert property (
        (state == ST_CMD_ACK && $past(state) == ST_CMD) |->
            sda_oe == (shreg <= gauge_i2c_pkg::LAST_READ_LOC))
        else $error("command ack wrong for location");
    chk_read_only_nack: assert property (
        (state == ST_WDATA_ACK && $past(state) == ST_WDATA) |->
            sda_oe == !$past(loc_read_only) && wr_en == sda_oe)
        else $error("write ack wrong for read-only location");
    chk_write_ptr_step: assert property (
        (state == ST_WDATA && $past(state) == ST_WDATA_ACK && $past(acked)) |->
            ptr == 8'($past(ptr) + 8'h01))
        else $error("pointer did not step after write");
    chk_read_ptr_step: assert property (
        ($past(state) == ST_RDATA_ACK && $past(rise) && !$past(sda_s) &&
         $past(nrst) && !$past(bus_release) && !$past(start) && !$past(stop)) |->
            ptr == 8'($past(ptr) + 8'h01))
        else $error("pointer did not step after controller ack");
    chk_quick_read_bit: assert property (
        (state == ST_RDATA && $past(state) == ST_ADDR_ACK) |-> sda_oe == !$past(rd_data[7]))
        else $error("first read bit not from pointer location");
    chk_stretch_bound: assert property (
        scl_oe |-> stretch_cnt < stretch_cap)
        else $error("stretch ran past its bound");
    chk_foreign_stretch: assert property (
        $rose(scl_oe) && !stretch_wake |-> $past(addressed) && $past(power_state[1]) == 1'b0 ||
            $past(addressed))
        else $error("stretched traffic for another target");
    chk_release_lines: assert property (
        bus_release |=> !scl_oe && !sda_oe && state == ST_IDLE)
        else $error("lines not released on stuck bus");
    chk_release_cause: assert property (
        bus_release |-> !(scl_d && sda_d))
        else $error("released while bus was high");

    cov_quick_read: cover property (state == ST_ADDR_ACK && rd_mode ##[1:1000] state == ST_RDATA);
    cov_write_ack: cover property (wr_en);
    cov_wake_stretch: cover property ($rose(scl_oe) && stretch_wake);
    cov_stuck_sleep: cover property ($rose(engine_sleep));
endmodule

// ### testbench/host_ctrl.sv
// Bus controller model that clocks the two-wire bus against the target port.
// Assumes the bench resolves both wires from every party's pull-down.
`timescale 1ns/1ps

module host_ctrl #(
    parameter int HALF = 10,
    parameter int GAP = 200
) (
    // Clock
    input wire logic clk,
    // Resolved wires
    input wire logic scl,
    input wire logic sda,
    // Pull-downs
    output logic scl_low,
    output logic sda_low
);
    int hang = 0;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    // ==========================================
    // Stretch tolerance, bounded so a stuck clock cannot hang the run
    task automatic free_scl();
        int n;
        n = 0;
        scl_low = 1'b0;
        @(negedge clk);
        while (scl !== 1'b1 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 4000) hang++;
        wait_n(HALF);
    endtask
    // ==========================================
    // Framing
    task automatic start_c();
        sda_low = 1'b0;
        wait_n(HALF);
        free_scl();
        sda_low = 1'b1;
        wait_n(HALF);
        scl_low = 1'b1;
    endtask
    task automatic stop_c();
        wait_n(2);
        sda_low = 1'b1;
        wait_n(HALF);
        free_scl();
        sda_low = 1'b0;
        // No command results are polled, so the stop gap is the only wait owed
        wait_n(GAP);
    endtask
    // Data moves two cycles after the fall, so it never mimics a start or stop
    task automatic bit_c(input logic b, output logic r);
        wait_n(2);
        sda_low = ~b;
        wait_n(HALF);
        free_scl();
        r = sda;
        scl_low = 1'b1;
    endtask
    task automatic byte_c(input logic [7:0] d, input logic ack, output logic [7:0] q,
                          output logic nak);
        for (int i = 7; i >= 0; i--) bit_c(d[i], q[i]);
        bit_c(~ack, nak);
    endtask
endmodule

// ### testbench/gauge_i2c_slave_port_bench.sv
// Self-checking bench for the gauge bus target port.
// Assumes host_ctrl as controller and a command space answering ptr ^ 0x3c.
`timescale 1ns/1ps

module gauge_i2c_slave_port_bench;
    localparam int WF = 20;
    localparam int WS = 40;
    localparam int HS = 50;
    logic clk, nrst, scl_oe, sda_oe, scl_low, sda_low, scl, sda, wr_en, engine_sleep, nak;
    logic loc_read_only, store_busy, scl_out, sda_out;
    logic [7:0] ptr, wr_data, rd_data, wake_cfg, bus_stuck_limit, q, c, d0, d1, a;
    logic [1:0] power_state;
    logic [2:0] stretch_kind;
    logic [7:0] bad[3] = '{8'h6c, 8'h80, 8'hff};
    logic [15:0] wq[$];
    int err_total = 0, checks = 0, cyc = 0, run = 0, max_run = 0, seed;
    assign scl = ~(scl_low | scl_oe);
    assign sda = ~(sda_low | sda_oe);
    assign rd_data = exp_rd(ptr);
    always #2.5 clk = ~clk;

    gauge_i2c_slave_port #(.WAKE_FAST_CYC(WF), .WAKE_SLOW_CYC(WS), .MS_CYC(10),
        .HALF_SEC_CYC(HS)) dut (.clk(clk), .nrst(nrst), .scl_in(scl), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .ptr(ptr),
        .rd_data(rd_data), .loc_read_only(loc_read_only), .wr_en(wr_en),
        .wr_data(wr_data), .power_state(power_state), .wake_cfg(wake_cfg),
        .store_busy(store_busy), .stretch_kind(stretch_kind),
        .bus_stuck_limit(bus_stuck_limit), .engine_sleep(engine_sleep));
    host_ctrl host (.clk(clk), .scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low));

    // ==========================================
    // Monitors and timeout
    always @(posedge clk) begin
        cyc <= cyc + 1;
        run <= (scl_oe === 1'b1) ? run + 1 : 0;
        if (run > max_run) max_run <= run;
        if (wr_en === 1'b1) wq.push_back({ptr, wr_data});
        if (cyc == 80000 || host.hang > 0) begin
            err_total++;
            wrap_up();
        end
    end
    // ==========================================
    // Helpers
    function automatic logic [7:0] exp_rd(input logic [7:0] p);
        return p ^ 8'h3c;
    endfunction
    function automatic int cap_ms(input int k);
        int t[6] = '{24, 72, 116, 144, 80, 270};
        return t[k];
    endfunction
    function automatic logic [15:0] near(input int got, input int exp);
        return {15'h0, got >= exp - 2 && got <= exp + 2};
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tx(input logic [7:0] b, input logic no_ack);
        host.byte_c(b, 1'b0, q, nak);
        chk("ack bit", {15'h0, no_ack}, {15'h0, nak});
    endtask
    task automatic rx(input logic [7:0] exp, input logic more);
        host.byte_c(8'hff, more, q, nak);
        chk("read byte", exp, q);
    endtask
    task automatic foreign();
        host.start_c();
        tx(a, 1'b1);
        host.stop_c();
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        seed = 32'h9a84d530;
        {clk, nrst, loc_read_only, store_busy} = 4'h0;
        power_state = 2'h0;
        stretch_kind = 3'h0;
        {wake_cfg, bus_stuck_limit} = 16'h0;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        chk("ptr", 8'h00, ptr);
        c = $random(seed);
        c = c % 8'h6b;
        d0 = $random(seed);
        d1 = $random(seed);
        a = $random(seed);
        if (a[7:1] == 7'h55) a = 8'h54;
        host.start_c();
        tx(8'haa, 1'b0);
        tx(c, 1'b0);
        tx(d0, 1'b0);
        tx(d1, 1'b0);
        host.stop_c();
        chk("wr count", 16'h2, 16'(wq.size()));
        chk("wr first", {c, d0}, wq[0]);
        chk("wr second", {c + 8'h01, d1}, wq[1]);
        chk("ptr", c + 8'h02, ptr);
        done("write");
        host.start_c();
        tx(8'hab, 1'b0);
        rx(exp_rd(c + 8'h02), 1'b1);
        rx(exp_rd(c + 8'h03), 1'b0);
        host.stop_c();
        chk("ptr", c + 8'h03, ptr);
        host.start_c();
        tx(8'haa, 1'b0);
        tx(8'h6b, 1'b0);
        host.start_c();
        tx(8'hab, 1'b0);
        rx(exp_rd(8'h6b), 1'b0);
        host.stop_c();
        done("read");
        foreach (bad[i]) begin
            host.start_c();
            tx(8'haa, 1'b0);
            tx(bad[i], 1'b1);
            host.stop_c();
        end
        loc_read_only = 1'b1;
        wq.delete();
        host.start_c();
        tx(8'haa, 1'b0);
        tx(c, 1'b0);
        tx(d0, 1'b1);
        tx(d1, 1'b1);
        host.stop_c();
        loc_read_only = 1'b0;
        chk("wr count", 16'h0, 16'(wq.size()));
        chk("ptr", c, ptr);
        done("refusals");
        store_busy = 1'b1;
        power_state = 2'h1;
        max_run = 0;
        foreign();
        chk("foreign stretch", 16'h0, 16'(max_run));
        for (int k = 0; k < 6; k++) begin
            stretch_kind = 3'(k);
            max_run = 0;
            host.start_c();
            tx(8'hab, 1'b0);
            host.byte_c(8'hff, 1'b0, q, nak);
            host.stop_c();
            chk("busy stretch", 16'h1, near(max_run, cap_ms(k) * 10));
        end
        store_busy = 1'b0;
        for (int k = 0; k < 2; k++) begin
            power_state = k ? 2'h3 : 2'h2;
            wake_cfg = k ? 8'h00 : 8'h09;
            max_run = 0;
            foreign();
            chk("wake stretch", 16'h1, near(max_run, k ? WS : WF));
        end
        power_state = 2'h0;
        done("stretch");
        // A stretch that outlives the stuck limit must be cut short
        bus_stuck_limit = 8'h01;
        store_busy = 1'b1;
        max_run = 0;
        host.start_c();
        tx(8'hab, 1'b0);
        host.byte_c(8'hff, 1'b0, q, nak);
        host.stop_c();
        store_busy = 1'b0;
        chk("stuck release", 16'h1, {15'h0, max_run > 0 && max_run <= HS});
        // Two short lows split by a high gap must not add up
        bus_stuck_limit = 8'h01;
        host.scl_low = 1'b1;
        repeat (40) @(negedge clk);
        host.scl_low = 1'b0;
        repeat (6) @(negedge clk);
        host.scl_low = 1'b1;
        repeat (40) @(negedge clk);
        chk("sleep", 16'h0, {15'h0, engine_sleep});
        repeat (40) @(negedge clk);
        chk("sleep", 16'h1, {15'h0, engine_sleep});
        chk("oe", 16'h0, {12'h0, scl_out, sda_out, scl_oe, sda_oe});
        host.scl_low = 1'b0;
        repeat (10) @(negedge clk);
        chk("sleep", 16'h0, {15'h0, engine_sleep});
        done("stuck");
        wrap_up();
    end
endmodule
